// [design/prbs_checker_top.sv]
// Behaviour
// - compare each lane's bits without link alignment
// - self-lock onto selected sequence, no seed
// - sequence select 00/01/10, reset 00
// - lane enable bit n checks lane n
// - many lanes checked, one tally shown
// - clear bit pulsed; clears checker while high
// - 24-bit error limit over three byte registers
// - run rising edge starts, written zero stops
// - pass register: one bit per lane
// - three-bit field selects lane of tally
// - 24-bit tally over three bytes, saturating
//
// Register access over APB is this design's own decision.
module prbs_checker_top
(
  // clock and reset
  input  wire logic                        clk_sys,
  input  wire logic                        rst_n,
  // register bus
  input  wire prbs_check_pkg::apb_req_t    apb_req,
  output prbs_check_pkg::apb_rsp_t         apb_rsp,
  // received lane bits from the physical layer
  input  wire logic [prbs_check_pkg::LANES-1:0] lane_bits,
  input  wire logic                        lane_bits_valid,
  // interrupt
  output logic                             irq
);
  import prbs_check_pkg::*;

  typedef struct packed {
    logic [7:0]       lane_en;
    logic [7:0]       ctrl;
    logic [CNT_W-1:0] limit;
    logic [7:0]       pass;
    logic             active;
    logic             run_q;
    logic             sat_q;
    logic [EV_W-1:0]  status;
    logic [EV_W-1:0]  mask;
    logic             pready;
    logic [31:0]      prdata;
    logic             pslverr;
    logic             irq;
  } top_state_t;

  top_state_t st_ff;
  top_state_t nxt_st;
  logic       rst_s_n;

  logic [CNT_W-1:0] counts [LANES];
  logic [LANES-1:0] sat_lane;
  logic [LANES-1:0] verdict;
  logic [CNT_W-1:0] tally_view;
  logic [IDX_W-1:0] idx;
  logic             hit;
  logic [31:0]      rdata;
  logic             access;
  logic             done;
  logic             clear_bit;
  logic             run_bit;
  logic [EV_W-1:0]  events;
  seq_t             seq_sel;

  rst_sync u_rst_sync
  (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .rst_sync_n (rst_s_n)
  );

  assign clear_bit = st_ff.ctrl[CTRL_CLEAR];
  assign run_bit   = st_ff.ctrl[CTRL_RUN];
  assign seq_sel   = seq_t'(st_ff.ctrl[CTRL_SEQ_LO +: 2]);

  // every lane runs its own checker in parallel
  genvar g;
  generate
    for (g = 0; g < LANES; g++)
    begin : g_lane
      prbs_lane_check u_lane
      (
        .clk_sys   (clk_sys),
        .rst_n     (rst_s_n),
        .clear     (clear_bit),
        .check_en  (st_ff.active && st_ff.lane_en[g]),
        .seq       (seq_sel),
        .bit_valid (lane_bits_valid),
        .bit_in    (lane_bits[g]),
        .err_count (counts[g]),
        .saturated (sat_lane[g])
      );
      // disabled lanes are never reported as passing
      assign verdict[g] = st_ff.lane_en[g] &&
                          !(counts[g] > st_ff.limit);
    end
  endgenerate

  // only one lane's tally is visible at a time
  assign tally_view = counts[st_ff.ctrl[CTRL_SEL_LO +: 3]];

  assign idx    = apb_req.paddr[ADDR_W-1:2];
  assign access = apb_req.psel && apb_req.penable;
  assign done   = access && st_ff.pready;

  // address decode and read mux
  always_comb
  begin
    hit   = 1'b1;
    rdata = 32'h00000000;
    if (apb_req.paddr[1:0] != 2'h0)
      hit = 1'b0;
    else if (idx == IDX_LANE_EN)
      rdata[7:0] = st_ff.lane_en;
    else if (idx == IDX_CTRL)
      rdata[7:0] = st_ff.ctrl;
    else if (idx == IDX_LIMIT0)
      rdata[7:0] = st_ff.limit[7:0];
    else if (idx == IDX_LIMIT1)
      rdata[7:0] = st_ff.limit[15:8];
    else if (idx == IDX_LIMIT2)
      rdata[7:0] = st_ff.limit[23:16];
    else if (idx == IDX_TALLY0)
      rdata[7:0] = tally_view[7:0];
    else if (idx == IDX_TALLY1)
      rdata[7:0] = tally_view[15:8];
    else if (idx == IDX_TALLY2)
      rdata[7:0] = tally_view[23:16];
    else if (idx == IDX_PASS)
      rdata[7:0] = st_ff.pass;
    else if (idx == IDX_IRQ_STAT)
      rdata[EV_W-1:0] = st_ff.status;
    else if (idx == IDX_IRQ_MASK)
      rdata[EV_W-1:0] = st_ff.mask;
    else
      hit = 1'b0;
  end

  always_comb
  begin
    nxt_st         = st_ff;
    nxt_st.pready  = 1'b0;
    nxt_st.pslverr = 1'b0;
    events         = '0;

    // one wait state: answer is registered, so pready comes from a flop
    if (access && !st_ff.pready)
    begin
      nxt_st.pready  = 1'b1;
      nxt_st.pslverr = !hit;
      nxt_st.prdata  = apb_req.pwrite ? 32'h00000000 : rdata;
    end

    // writes take effect only at the completing edge
    if (done && apb_req.pwrite && hit)
    begin
      if (idx == IDX_LANE_EN)
        nxt_st.lane_en = apb_req.pwdata[7:0];
      else if (idx == IDX_CTRL)
        nxt_st.ctrl = {1'b0, apb_req.pwdata[6:0]};
      else if (idx == IDX_LIMIT0)
        nxt_st.limit[7:0] = apb_req.pwdata[7:0];
      else if (idx == IDX_LIMIT1)
        nxt_st.limit[15:8] = apb_req.pwdata[7:0];
      else if (idx == IDX_LIMIT2)
        nxt_st.limit[23:16] = apb_req.pwdata[7:0];
      else if (idx == IDX_IRQ_MASK)
        nxt_st.mask = apb_req.pwdata[EV_W-1:0];
    end

    // test sequencing; relies on the far end already sending
    nxt_st.run_q = run_bit;
    if (clear_bit)
    begin
      nxt_st.active = 1'b0;
      nxt_st.pass   = 8'h00;
    end
    else if (run_bit && !st_ff.run_q)
      nxt_st.active = 1'b1;
    else if (!run_bit && st_ff.active)
    begin
      nxt_st.active = 1'b0;
      nxt_st.pass   = verdict;
      events[EV_DONE] = 1'b1;
      events[EV_FAIL] = |(st_ff.lane_en & ~verdict);
    end

    nxt_st.sat_q = |(sat_lane & st_ff.lane_en);
    events[EV_SAT] = nxt_st.sat_q && !st_ff.sat_q;

    // read clears status; a new event in the same cycle still lands
    if (done && !apb_req.pwrite && hit && idx == IDX_IRQ_STAT)
      nxt_st.status = events;
    else
      nxt_st.status = st_ff.status | events;

    nxt_st.irq = |(nxt_st.status & nxt_st.mask);
  end

  always_ff @(posedge clk_sys or negedge rst_s_n)
  begin
    if (!rst_s_n)
    begin
      st_ff         <= '0;
      st_ff.ctrl    <= CTRL_RST;
      st_ff.lane_en <= LANE_EN_RST;
      st_ff.limit   <= LIMIT_RST;
      st_ff.mask    <= MASK_RST;
    end
    else
      st_ff <= nxt_st;
  end

  assign apb_rsp.pready  = st_ff.pready;
  assign apb_rsp.prdata  = st_ff.prdata;
  assign apb_rsp.pslverr = st_ff.pslverr;
  assign irq             = st_ff.irq;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_s_n);

  a_clear_zeroes: assert property (
    clear_bit |=> (counts[0] == '0) && (counts[LANES-1] == '0) && !st_ff.active)
    else $error("clear did not empty checker");
  a_run_starts: assert property (
    run_bit && !st_ff.run_q && !clear_bit |=> st_ff.active)
    else $error("run edge did not start test");
  a_stop_ends: assert property (
    !run_bit |=> !st_ff.active)
    else $error("test kept running after stop");
  a_pass_verdict: assert property (
    st_ff.active && !run_bit && !clear_bit |=> st_ff.pass == $past(verdict))
    else $error("pass flags not latched at stop");
  a_lane_idle: assert property (
    !st_ff.lane_en[0] && !clear_bit |=> $stable(counts[0]))
    else $error("disabled lane counted");
  a_tally_read: assert property (
    access && !st_ff.pready && !apb_req.pwrite && idx == IDX_TALLY0 &&
    apb_req.paddr[1:0] == 2'h0
    |=> apb_rsp.pready && apb_rsp.prdata[7:0] == $past(tally_view[7:0]))
    else $error("tally read wrong");
  a_bus_answer: assert property (
    access && !st_ff.pready |=> apb_rsp.pready ##1 !apb_rsp.pready)
    else $error("bus answer not one cycle");

  // irq is a pure function of registered status and mask
  a_irq_level: assert property (
    irq == |(st_ff.status & st_ff.mask))
    else $error("irq does not follow masked status");

  a_ctrl_top_zero: assert property (
    !st_ff.ctrl[7])
    else $error("control bit 7 set");

  a_clear_pass: assert property (
    clear_bit |=> st_ff.pass == 8'h00)
    else $error("clear left pass flags set");

  a_idle_frozen: assert property (
    !st_ff.active && !clear_bit |=> $stable(counts[3]))
    else $error("lane counted while test stopped");

  a_active_run: assert property (
    st_ff.active |-> st_ff.run_q)
    else $error("test active without run bit");

  a_misaligned_err: assert property (
    access && !st_ff.pready && apb_req.paddr[1:0] != 2'h0
    |=> apb_rsp.pslverr)
    else $error("misaligned access not refused");

  a_ctrl_write: assert property (
    done && apb_req.pwrite && idx == IDX_CTRL && apb_req.paddr[1:0] == 2'h0
    |=> st_ff.ctrl == {1'b0, $past(apb_req.pwdata[6:0])})
    else $error("control write lost");

  a_limit_write: assert property (
    done && apb_req.pwrite && idx == IDX_LIMIT2 && apb_req.paddr[1:0] == 2'h0
    |=> st_ff.limit[23:16] == $past(apb_req.pwdata[7:0]))
    else $error("limit high byte write lost");

  a_enable_write: assert property (
    done && apb_req.pwrite && idx == IDX_LANE_EN && apb_req.paddr[1:0] == 2'h0
    |=> st_ff.lane_en == $past(apb_req.pwdata[7:0]))
    else $error("lane enable write lost");

  // set wins over read-clear, so done must always land
  a_done_event: assert property (
    st_ff.active && !run_bit && !clear_bit |=> st_ff.status[EV_DONE])
    else $error("done event lost");

  a_sat_event: assert property (
    !st_ff.sat_q && |(sat_lane & st_ff.lane_en) |=> st_ff.status[EV_SAT])
    else $error("saturation event lost");

  a_read_upper: assert property (
    apb_rsp.pready |-> apb_rsp.prdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");

endmodule // prbs_checker_top

// [design/prbs_check_pkg.sv]
package prbs_check_pkg;

  localparam int LANES  = 8;
  localparam int CNT_W  = 24;
  localparam int HIST_W = 31;
  localparam int ADDR_W = 12;
  localparam int IDX_W  = 10;
  localparam int EV_W   = 3;

  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_LANE_EN  = 10'h315;
  localparam logic [IDX_W-1:0] IDX_CTRL     = 10'h316;
  localparam logic [IDX_W-1:0] IDX_LIMIT0   = 10'h317;
  localparam logic [IDX_W-1:0] IDX_LIMIT1   = 10'h318;
  localparam logic [IDX_W-1:0] IDX_LIMIT2   = 10'h319;
  localparam logic [IDX_W-1:0] IDX_TALLY0   = 10'h31a;
  localparam logic [IDX_W-1:0] IDX_TALLY1   = 10'h31b;
  localparam logic [IDX_W-1:0] IDX_TALLY2   = 10'h31c;
  localparam logic [IDX_W-1:0] IDX_PASS     = 10'h31d;
  localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 10'h31e;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 10'h31f;

  // check_control field positions
  localparam int CTRL_CLEAR  = 0;
  localparam int CTRL_RUN    = 1;
  localparam int CTRL_SEQ_LO = 2;
  localparam int CTRL_SEL_LO = 4;

  // reset values
  localparam logic [7:0]      CTRL_RST    = 8'h00;
  localparam logic [7:0]      LANE_EN_RST = 8'h00;
  localparam logic [CNT_W-1:0] LIMIT_RST  = 24'h000000;
  localparam logic [EV_W-1:0] MASK_RST    = 3'h0;

  // interrupt status bit positions
  localparam int EV_DONE = 0;
  localparam int EV_FAIL = 1;
  localparam int EV_SAT  = 2;

  // generator taps, counted from the newest history bit at 0
  localparam int P7_A  = 6;
  localparam int P7_B  = 5;
  localparam int P15_A = 14;
  localparam int P15_B = 13;
  localparam int P31_A = 30;
  localparam int P31_B = 27;
  localparam logic [4:0] LOCK7  = 5'h07;
  localparam logic [4:0] LOCK15 = 5'h0f;
  localparam logic [4:0] LOCK31 = 5'h1f;

  typedef enum logic [1:0] {
    SEQ_PRBS7  = 2'b00,
    SEQ_PRBS15 = 2'b01,
    SEQ_PRBS31 = 2'b10
  } seq_t;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
  } apb_req_t;

  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } apb_rsp_t;

  typedef struct packed {
    logic [HIST_W-1:0] hist;
    logic [4:0]        fill;
    logic [CNT_W-1:0]  count;
  } lane_state_t;

endpackage

// [design/rst_sync.sv]
module rst_sync
(
  // clock and raw reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // released copy
  output logic      rst_sync_n
);

  logic [1:0] stage_ff;

  // assert at once, release after two edges
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      stage_ff <= 2'h0;
    else
      stage_ff <= {stage_ff[0], 1'b1};
  end

  assign rst_sync_n = stage_ff[1];

endmodule // rst_sync

// [design/prbs_lane_check.sv]
module prbs_lane_check
(
  // clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       rst_n,
  // control
  input  wire logic                       clear,
  input  wire logic                       check_en,
  input  wire prbs_check_pkg::seq_t       seq,
  // received lane bit
  input  wire logic                       bit_valid,
  input  wire logic                       bit_in,
  // result
  output logic [prbs_check_pkg::CNT_W-1:0] err_count,
  output logic                             saturated
);
  import prbs_check_pkg::*;

  lane_state_t st_ff;
  lane_state_t nxt_st;
  logic        expected;
  logic        locked;

  // self-synchronising: history is the received stream, so no seed needed
  always_comb
  begin
    nxt_st = st_ff;
    case (seq)
      SEQ_PRBS15:
      begin
        expected = st_ff.hist[P15_A] ^ st_ff.hist[P15_B];
        locked   = st_ff.fill >= LOCK15;
      end
      SEQ_PRBS31:
      begin
        expected = st_ff.hist[P31_A] ^ st_ff.hist[P31_B];
        locked   = st_ff.fill >= LOCK31;
      end
      default:
      begin
        expected = st_ff.hist[P7_A] ^ st_ff.hist[P7_B];
        locked   = st_ff.fill >= LOCK7;
      end
    endcase
    if (clear)
      nxt_st = '0;
    else if (check_en && bit_valid)
    begin
      nxt_st.hist = {st_ff.hist[HIST_W-2:0], bit_in};
      if (!locked)
        nxt_st.fill = st_ff.fill + 5'h01;
      else if ((bit_in != expected) && !(&st_ff.count))
        nxt_st.count = st_ff.count + 24'h000001;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign err_count = st_ff.count;
  assign saturated = &st_ff.count;

  a_sat_holds: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (&st_ff.count) && !clear |=> (&st_ff.count))
    else $error("saturated count moved");
  a_count_step: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !clear && !$past(clear) && !(&$past(st_ff.count))
    |-> (st_ff.count - $past(st_ff.count)) <= 24'h000001)
    else $error("count stepped by more than one");
  a_match_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n)
    locked && !clear && bit_valid && (bit_in == expected) |=> $stable(st_ff.count))
    else $error("count moved on a matching bit");

endmodule // prbs_lane_check

// [verification/prbs_tx_model.sv]
module prbs_tx_model
(
  // clock and reset
  input  wire logic                               clk_sys,
  input  wire logic                               rst_n,
  // control from the bench
  input  wire prbs_check_pkg::seq_t               seq,
  input  wire logic                               run,
  input  wire logic [prbs_check_pkg::LANES-1:0]   flip,
  // serial lanes towards the checker
  output logic [prbs_check_pkg::LANES-1:0]        lanes,
  output logic                                    lanes_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  import prbs_check_pkg::*;

  logic [30:0] gen_ff;
  logic        nxt_bit;

  // taps written as plain numbers, independent of the design's constants
  always_comb
  begin
    case (seq)
      SEQ_PRBS15: nxt_bit = gen_ff[14] ^ gen_ff[13];
      SEQ_PRBS31: nxt_bit = gen_ff[30] ^ gen_ff[27];
      default:    nxt_bit = gen_ff[6] ^ gen_ff[5];
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gen_ff      <= '1;
      lanes       <= '0;
      lanes_valid <= 1'b0;
    end
    else if (run)
    begin
      // same stream on every lane; flip injects one wrong bit
      gen_ff      <= {gen_ff[29:0], nxt_bit};
      lanes       <= {LANES{nxt_bit}} ^ flip;
      lanes_valid <= 1'b1;
    end
    else
    begin
      // idle lanes toggle so no stale bit looks valid
      lanes       <= ~lanes;
      lanes_valid <= 1'b0;
    end
  end
endmodule // prbs_tx_model

// [verification/serial_lane_prbs_checker_bench.sv]
module serial_lane_prbs_checker_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import prbs_check_pkg::*;

  logic             clk_sys = 1'b0;
  logic             rst_n = 1'b0;
  apb_req_t         apb_req = '0;
  apb_rsp_t         apb_rsp;
  logic [LANES-1:0] lanes;
  logic             lanes_valid;
  logic             irq;
  seq_t             tx_seq = SEQ_PRBS7;
  logic             tx_run = 1'b0;
  logic [LANES-1:0] tx_flip = '0;
  logic [31:0]      rdata;
  logic             rerr;
  int               num_errors = 0;
  int               checks_done = 0;

  always #50 clk_sys = ~clk_sys;

  prbs_checker_top u_prbs_checker_top (
    .clk_sys(clk_sys), .rst_n(rst_n), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .lane_bits(lanes), .lane_bits_valid(lanes_valid),
    .irq(irq));

  prbs_tx_model u_prbs_tx_model (
    .clk_sys(clk_sys), .rst_n(rst_n), .seq(tx_seq), .run(tx_run),
    .flip(tx_flip), .lanes(lanes), .lanes_valid(lanes_valid));

  task automatic end_sim();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one transfer; idle cycle before setup so psel is never assigned twice
  task automatic apb(input logic wr, input logic [IDX_W-1:0] idx,
                     input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge clk_sys);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr,
                 paddr: {idx, 2'b00}, pwdata: {24'h0, wd}};
    @(posedge clk_sys);
    apb_req.penable <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (apb_rsp.pready !== 1'b1 && n < 20);
    rdata = apb_rsp.prdata;
    rerr = apb_rsp.pslverr;
    apb_req <= '0;
    if (n >= 20)
    begin
      num_errors++;
      $display("[ERR] %0t bus answer missing", $time);
      end_sim();
    end
  endtask

  task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask

  task automatic rd_chk(input logic [IDX_W-1:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    check_val(rdata, {24'h0, exp});
    check_val({31'h0, rerr}, 32'h0);
  endtask

  task automatic tally_chk(input logic [2:0] lane, input seq_t s,
                           input logic [23:0] exp);
    wr(IDX_CTRL, {1'b0, lane, s, 2'b00});
    rd_chk(IDX_TALLY0, exp[7:0]);
    rd_chk(IDX_TALLY1, exp[15:8]);
    rd_chk(IDX_TALLY2, exp[23:16]);
  endtask

  task automatic t_reset_values();
    rd_chk(IDX_CTRL, CTRL_RST);
    rd_chk(IDX_LANE_EN, LANE_EN_RST);
    rd_chk(IDX_LIMIT0, LIMIT_RST[7:0]);
    rd_chk(IDX_PASS, 8'h00);
    rd_chk(IDX_IRQ_MASK, {5'h0, MASK_RST});
    wr(IDX_PASS, 8'hff);
    rd_chk(IDX_PASS, 8'h00);
    apb(1'b0, 10'h320, 8'h00);
    check_val(rdata, 32'h0);
    check_val({31'h0, rerr}, 32'h1);
  endtask

  // one flipped bit on lane 3, counted as three errors; lane 7 left disabled
  task automatic t_run(input seq_t s, input logic [7:0] lim);
    logic fail;
    fail = (lim < 8'h03);
    tx_seq <= s;
    repeat (40) @(posedge clk_sys);
    wr(IDX_LANE_EN, 8'h7f);
    wr(IDX_CTRL, {4'h0, s, 2'b01});
    wr(IDX_CTRL, {4'h0, s, 2'b00});
    wr(IDX_LIMIT0, lim);
    wr(IDX_LIMIT1, 8'h00);
    wr(IDX_LIMIT2, 8'h00);
    wr(IDX_CTRL, {4'h0, s, 2'b10});
    repeat (60) @(posedge clk_sys);
    tx_flip <= 8'h08;
    @(posedge clk_sys);
    tx_flip <= 8'h00;
    repeat (60) @(posedge clk_sys);
    wr(IDX_CTRL, {4'h0, s, 2'b00});
    repeat (3) @(posedge clk_sys);
    check_val({31'h0, irq}, 32'h1);
    rd_chk(IDX_PASS, fail ? 8'h77 : 8'h7f);
    tally_chk(3'd3, s, 24'd3);
    tally_chk(3'd0, s, 24'd0);
    rd_chk(IDX_IRQ_STAT, {6'h0, fail, 1'b1});
    repeat (3) @(posedge clk_sys);
    check_val({31'h0, irq}, 32'h0);
    wr(IDX_CTRL, {4'h0, s, 2'b01});
    tally_chk(3'd3, s, 24'd0);
    rd_chk(IDX_PASS, 8'h00);
  endtask

  initial
  begin
    #1000000;
    num_errors++;
    $display("[ERR] %0t run did not finish", $time);
    end_sim();
  end

  initial
  begin
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    tx_run <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_reset_values();
    wr(IDX_IRQ_MASK, 8'h01);
    t_run(SEQ_PRBS7, 8'h02);
    t_run(SEQ_PRBS15, 8'h03);
    t_run(SEQ_PRBS31, 8'h04);
    end_sim();
  end
endmodule // serial_lane_prbs_checker_bench
